// >>> hw/fir_ctrl_pkg.sv
package fir_ctrl_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int DATA_W     = 16;
   localparam int COEF_W     = 16;
   localparam int FACTOR_W   = 9;
   localparam int NUM_TAPS   = 64;
   localparam int TAP_AW     = 6;
   localparam int POS_W      = 12;
   localparam int AXI_AW     = 8;
   localparam int AXI_DW     = 32;
   localparam int LEVEL_W    = 2;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [AXI_AW-1:0] OFF_CTRL       = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_STATUS     = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_FACTOR     = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_COEF_COUNT = 8'h0C;
   localparam logic [AXI_AW-1:0] OFF_COEF_SEL   = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_COEF_DATA  = 8'h14;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_REORDER_BIT = 0;
   localparam int CTRL_SYM_BIT     = 1;
   localparam int CTRL_HALF_BIT    = 2;
   localparam int CTRL_W           = 3;
   localparam int ST_READY_BIT     = 0;
   localparam int ST_VALID_BIT     = 1;
   localparam int ST_LOADING_BIT   = 2;
   localparam int ST_BANK_BIT      = 3;
   localparam int ST_RECONF_BIT    = 4;
   localparam int ST_WAIT_BIT      = 5;

   // ****************************************************************
   // Reset values and timing
   // ****************************************************************
   localparam logic [CTRL_W-1:0]   CTRL_RESET   = 3'h0;
   localparam logic [FACTOR_W-1:0] FACTOR_RESET = 9'h002;
   localparam logic [3:0]          RECONF_CYCLES = 4'h4;
   localparam logic [1:0]          RESP_OKAY    = 2'h0;
   localparam logic [1:0]          RESP_SLVERR  = 2'h2;

   // ****************************************************************
   // Coefficient load sequencing
   // ****************************************************************
   typedef enum logic [2:0] {
      LD_IDLE = 3'h1,
      LD_LOAD = 3'h2,
      LD_WAIT = 3'h4
   } load_state_t;

endpackage

// >>> hw/sample_stream_if.sv
`timescale 1ns/1ps
interface sample_stream_if;
   logic [fir_ctrl_pkg::DATA_W-1:0]  data;
   logic                             valid;
   logic                             ready;
   logic [fir_ctrl_pkg::LEVEL_W-1:0] level;

   modport src (output data, output valid, input ready, input level);
   modport snk (input data, input valid, output ready, output level);
endinterface

// >>> hw/two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer (
   input  wire logic      clk_sys,
   input  wire logic      rst,
   sample_stream_if.snk   inPort,
   sample_stream_if.src   outPort
);

   logic [fir_ctrl_pkg::DATA_W-1:0]  head_q;
   logic [fir_ctrl_pkg::DATA_W-1:0]  tail_q;
   logic [fir_ctrl_pkg::LEVEL_W-1:0] count_q;
   logic                             push;
   logic                             pop;
   logic                             loadHead;
   logic                             loadTail;
   logic                             shiftHead;

   assign inPort.ready  = (count_q != 2'h2);
   assign inPort.level  = count_q;
   assign outPort.valid = (count_q != 2'h0);
   assign outPort.data  = head_q;

   assign push      = inPort.valid & inPort.ready;
   assign pop       = outPort.valid & outPort.ready;
   assign loadHead  = push & ((count_q == 2'h0) | (pop & count_q == 2'h1));
   assign loadTail  = push & (count_q == 2'h1) & ~pop;
   assign shiftHead = pop & (count_q == 2'h2);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_q <= 2'h0;
      end else begin
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Data words need no reset; valid comes from count
   always_ff @(posedge clk_sys) begin
      if (loadHead) begin
         head_q <= inPort.data;
      end else if (shiftHead) begin
         head_q <= tail_q;
      end
      if (loadTail) begin
         tail_q <= inPort.data;
      end
   end

endmodule // two_entry_buffer

// >>> hw/fir_coef_reload_factor_ctrl.sv
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fir_coef_reload_factor_ctrl (
   input  wire logic                                clk_sys,
   input  wire logic                                rst,
   input  wire logic [fir_ctrl_pkg::AXI_AW-1:0]     s_axi_awaddr,
   input  wire logic                                s_axi_awvalid,
   output logic                                     s_axi_awready,
   input  wire logic [fir_ctrl_pkg::AXI_DW-1:0]     s_axi_wdata,
   input  wire logic [3:0]                          s_axi_wstrb,
   input  wire logic                                s_axi_wvalid,
   output logic                                     s_axi_wready,
   output logic [1:0]                               s_axi_bresp,
   output logic                                     s_axi_bvalid,
   input  wire logic                                s_axi_bready,
   input  wire logic [fir_ctrl_pkg::AXI_AW-1:0]     s_axi_araddr,
   input  wire logic                                s_axi_arvalid,
   output logic                                     s_axi_arready,
   output logic [fir_ctrl_pkg::AXI_DW-1:0]          s_axi_rdata,
   output logic [1:0]                               s_axi_rresp,
   output logic                                     s_axi_rvalid,
   input  wire logic                                s_axi_rready,
   input  wire logic [fir_ctrl_pkg::FACTOR_W-1:0]   factorIn,
   input  wire logic                                factorLoad,
   input  wire logic [fir_ctrl_pkg::COEF_W-1:0]     coefIn,
   input  wire logic                                coefWe,
   input  wire logic                                coefCommit,
   input  wire logic [fir_ctrl_pkg::DATA_W-1:0]     sampleIn,
   input  wire logic                                sampleValid,
   output logic                                     inputReady,
   output logic [fir_ctrl_pkg::DATA_W-1:0]          sampleOut,
   output logic                                     sampleOutValid,
   input  wire logic                                sampleOutReady,
   output logic [fir_ctrl_pkg::FACTOR_W-1:0]        activeFactor,
   output logic                                     activeBank
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [fir_ctrl_pkg::CTRL_W-1:0]     ctrl_q;
   logic [fir_ctrl_pkg::FACTOR_W-1:0]   factor_q;
   logic [3:0]                          reconf_q;
   logic                                bank_q;
   logic                                coefValid_q;
   fir_ctrl_pkg::load_state_t           state_q;
   fir_ctrl_pkg::load_state_t           state_d;
   logic [fir_ctrl_pkg::POS_W-1:0]      pos_q;
   logic [fir_ctrl_pkg::TAP_AW:0]       wrAddr_q;
   logic [fir_ctrl_pkg::TAP_AW:0]       activeCount_q;
   logic [fir_ctrl_pkg::TAP_AW-1:0]     coefSel_q;
   logic [fir_ctrl_pkg::COEF_W-1:0]     coefMem [0:2*fir_ctrl_pkg::NUM_TAPS-1];
   logic                                bvalid_q;
   logic [1:0]                          bresp_q;
   logic                                rvalid_q;
   logic [fir_ctrl_pkg::AXI_DW-1:0]     rdata_q;
   logic [1:0]                          rresp_q;

   logic                                reorderEn;
   logic                                symEn;
   logic                                halfEn;
   logic                                batchStart;
   logic [fir_ctrl_pkg::POS_W-1:0]      posBase;
   logic [fir_ctrl_pkg::POS_W-1:0]      posNum;
   logic [fir_ctrl_pkg::TAP_AW:0]       addrBase;
   logic                                keepSym;
   logic                                keepHalf;
   logic                                keepWord;
   logic                                memWrite;
   logic [fir_ctrl_pkg::TAP_AW:0]       memIndex;
   logic                                factorChange;
   logic                                pathReady;

   logic                                wrTake;
   logic                                rdTake;
   logic                                wrCtrl;
   logic                                wrSel;
   logic                                wrMapped;
   logic                                rdMapped;
   logic [fir_ctrl_pkg::AXI_DW-1:0]     rdValue;
   logic [fir_ctrl_pkg::AXI_DW-1:0]     statusWord;
   logic [fir_ctrl_pkg::COEF_W-1:0]     coefView;

   sample_stream_if                     inStream ();
   sample_stream_if                     outStream ();

   // ****************************************************************
   // Factor capture and reconfiguration
   // ****************************************************************
   assign factorChange = factorLoad & (factorIn != factor_q);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         factor_q <= fir_ctrl_pkg::FACTOR_RESET;
      end else if (factorLoad) begin
         factor_q <= factorIn;
      end
   end

   // Ready drops for a fixed settle time on every change
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reconf_q <= 4'h0;
      end else if (factorChange) begin
         reconf_q <= fir_ctrl_pkg::RECONF_CYCLES;
      end else if (reconf_q != 4'h0) begin
         reconf_q <= reconf_q - 4'h1;
      end
   end

   assign activeFactor = factor_q;

   // ****************************************************************
   // Coefficient reorder and trimming
   // ****************************************************************
   assign reorderEn  = ctrl_q[fir_ctrl_pkg::CTRL_REORDER_BIT];
   assign symEn      = ctrl_q[fir_ctrl_pkg::CTRL_SYM_BIT];
   assign halfEn     = ctrl_q[fir_ctrl_pkg::CTRL_HALF_BIT];
   assign batchStart = coefWe & (state_q != fir_ctrl_pkg::LD_LOAD);
   assign posBase    = batchStart ? 12'h000 : pos_q;
   assign posNum     = posBase + 12'h001;
   assign addrBase   = batchStart ? 7'h00 : wrAddr_q;

   // Natural order in, mirrored half dropped
   assign keepSym  = ~symEn |
                     (posNum <= 12'((fir_ctrl_pkg::NUM_TAPS + 1) / 2));
   // Odd positions kept, the final tap always kept
   assign keepHalf = ~halfEn | posNum[0] |
                     (posNum == 12'(fir_ctrl_pkg::NUM_TAPS));
   assign keepWord = ~reorderEn | (keepSym & keepHalf);

   // Words beyond the memory depth are dropped, not wrapped
   assign memWrite = coefWe & keepWord &
                     (addrBase < 7'(fir_ctrl_pkg::NUM_TAPS));
   assign memIndex = {~bank_q, addrBase[fir_ctrl_pkg::TAP_AW-1:0]};

   always_ff @(posedge clk_sys) begin
      if (memWrite) begin
         coefMem[memIndex] <= coefIn;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pos_q    <= 12'h000;
         wrAddr_q <= 7'h00;
      end else if (coefWe) begin
         pos_q    <= posNum;
         wrAddr_q <= addrBase + {6'h00, memWrite};
      end
   end

   // ****************************************************************
   // Load sequencing and bank swap
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         fir_ctrl_pkg::LD_IDLE: begin
            if (coefWe) begin
               state_d = fir_ctrl_pkg::LD_LOAD;
            end
         end
         fir_ctrl_pkg::LD_LOAD: begin
            // Enable may drop mid-batch; a write from LD_WAIT raises batchStart and restarts the batch at position 0
            if (coefCommit) begin
               state_d = fir_ctrl_pkg::LD_IDLE;
            end else if (!coefWe) begin
               state_d = fir_ctrl_pkg::LD_WAIT;
            end
         end
         fir_ctrl_pkg::LD_WAIT: begin
            if (coefCommit) begin
               state_d = fir_ctrl_pkg::LD_IDLE;
            end else if (coefWe) begin
               state_d = fir_ctrl_pkg::LD_LOAD;
            end
         end
         default: begin
            state_d = fir_ctrl_pkg::LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q       <= fir_ctrl_pkg::LD_IDLE;
         bank_q        <= 1'b0;
         coefValid_q   <= 1'b0;
         activeCount_q <= 7'h00;
      end else begin
         state_q <= state_d;
         if (coefCommit) begin
            bank_q        <= ~bank_q;
            coefValid_q   <= 1'b1;
            activeCount_q <= wrAddr_q;
         end
      end
   end

   assign activeBank = bank_q;

   // ****************************************************************
   // Sample path
   // ****************************************************************
   // Ready needs room for one late word after it falls
   assign pathReady  = (inStream.level == 2'h0) |
                       ((inStream.level == 2'h1) & sampleOutReady);
   assign inputReady = coefValid_q & (reconf_q == 4'h0) &
                       pathReady;

   assign inStream.data     = sampleIn;
   assign inStream.valid    = sampleValid;
   assign outStream.ready   = sampleOutReady;
   assign sampleOut         = outStream.data;
   assign sampleOutValid    = outStream.valid;

   two_entry_buffer sampleBuffer (
      .clk_sys (clk_sys),
      .rst     (rst),
      .inPort  (inStream),
      .outPort (outStream)
   );

   // ****************************************************************
   // Register bus write side
   // ****************************************************************
   assign wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign s_axi_awready = wrTake;
   assign s_axi_wready  = wrTake;
   assign wrCtrl   = wrTake & (s_axi_awaddr == fir_ctrl_pkg::OFF_CTRL);
   assign wrSel    = wrTake & (s_axi_awaddr == fir_ctrl_pkg::OFF_COEF_SEL);
   assign wrMapped = (s_axi_awaddr == fir_ctrl_pkg::OFF_CTRL) |
                     (s_axi_awaddr == fir_ctrl_pkg::OFF_COEF_SEL);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q    <= fir_ctrl_pkg::CTRL_RESET;
         coefSel_q <= 6'h00;
      end else begin
         // Mode bits change mid-batch at the user's risk
         if (wrCtrl && s_axi_wstrb[0]) begin
            ctrl_q <= s_axi_wdata[fir_ctrl_pkg::CTRL_W-1:0];
         end
         if (wrSel && s_axi_wstrb[0]) begin
            coefSel_q <= s_axi_wdata[fir_ctrl_pkg::TAP_AW-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= fir_ctrl_pkg::RESP_OKAY;
      end else if (wrTake) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wrMapped ? fir_ctrl_pkg::RESP_OKAY
                              : fir_ctrl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ****************************************************************
   // Register bus read side
   // ****************************************************************
   assign rdTake = s_axi_arvalid & ~rvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign coefView = coefMem[{bank_q, coefSel_q}];

   assign statusWord = {26'h000_0000,
                        state_q == fir_ctrl_pkg::LD_WAIT,
                        reconf_q != 4'h0,
                        bank_q,
                        state_q == fir_ctrl_pkg::LD_LOAD,
                        coefValid_q,
                        inputReady};

   assign rdMapped = (s_axi_araddr == fir_ctrl_pkg::OFF_CTRL) |
                     (s_axi_araddr == fir_ctrl_pkg::OFF_STATUS) |
                     (s_axi_araddr == fir_ctrl_pkg::OFF_FACTOR) |
                     (s_axi_araddr == fir_ctrl_pkg::OFF_COEF_COUNT) |
                     (s_axi_araddr == fir_ctrl_pkg::OFF_COEF_SEL) |
                     (s_axi_araddr == fir_ctrl_pkg::OFF_COEF_DATA);

   always_comb begin
      rdValue = 32'h0000_0000;
      if (s_axi_araddr == fir_ctrl_pkg::OFF_CTRL) begin
         rdValue[fir_ctrl_pkg::CTRL_W-1:0] = ctrl_q;
      end else if (s_axi_araddr == fir_ctrl_pkg::OFF_STATUS) begin
         rdValue = statusWord;
      end else if (s_axi_araddr == fir_ctrl_pkg::OFF_FACTOR) begin
         rdValue[fir_ctrl_pkg::FACTOR_W-1:0] = factor_q;
      end else if (s_axi_araddr == fir_ctrl_pkg::OFF_COEF_COUNT) begin
         rdValue[fir_ctrl_pkg::TAP_AW:0] = activeCount_q;
      end else if (s_axi_araddr == fir_ctrl_pkg::OFF_COEF_SEL) begin
         rdValue[fir_ctrl_pkg::TAP_AW-1:0] = coefSel_q;
      end else if (s_axi_araddr == fir_ctrl_pkg::OFF_COEF_DATA) begin
         rdValue[fir_ctrl_pkg::COEF_W-1:0] = coefView;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= fir_ctrl_pkg::RESP_OKAY;
      end else if (rdTake) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdValue;
         rresp_q  <= rdMapped ? fir_ctrl_pkg::RESP_OKAY
                              : fir_ctrl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule // fir_coef_reload_factor_ctrl

// >>> test/fir_coef_reload_factor_ctrl_sva.sv
`timescale 1ns/1ps
module fir_coef_reload_factor_ctrl_sva (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [8:0]  factorIn,
   input wire logic        factorLoad,
   input wire logic [8:0]  activeFactor,
   input wire logic        inputReady,
   input wire logic        coefCommit,
   input wire logic        activeBank,
   input wire logic        sampleValid,
   input wire logic [15:0] sampleOut,
   input wire logic        sampleOutValid,
   input wire logic        sampleOutReady
);
   // ****************
   // Helper state
   // ****************
   logic setSeen_q;
   // Set once a commit is seen; ready must wait for it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         setSeen_q <= 1'b0;
      end else if (coefCommit) begin
         setSeen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ****************
   // Checks
   // ****************
   chk_factor_capture:
      assert property (factorLoad |=> activeFactor == $past(factorIn))
      else $error("factor not captured");
   chk_ready_drop:
      assert property (factorLoad && factorIn != activeFactor
                       |=> !inputReady [*4])
      else $error("ready not low after factor change");
   chk_factor_steady:
      assert property (!factorLoad |=> $stable(activeFactor))
      else $error("factor moved without load");
   chk_ready_first:
      assert property (!setSeen_q |-> !inputReady)
      else $error("ready before first commit");
   chk_bank_swap:
      assert property (coefCommit |=> activeBank != $past(activeBank))
      else $error("bank not swapped on commit");
   chk_bank_hold:
      assert property (!coefCommit |=> $stable(activeBank))
      else $error("bank moved without commit");
   chk_sample_gate:
      assert property (!sampleValid && !sampleOutValid |=> !sampleOutValid)
      else $error("output without input sample");
   chk_out_hold:
      assert property (sampleOutValid && !sampleOutReady
                       |=> sampleOutValid && $stable(sampleOut))
      else $error("stalled output not held");
endmodule // fir_coef_reload_factor_ctrl_sva

// >>> test/upstream_src.sv
`timescale 1ns/1ps
module upstream_src (
   input  wire logic        clk_sys,
   input  wire logic        inputReady,
   output logic [8:0]       factorIn,
   output logic             factorLoad,
   output logic [15:0]      coefIn,
   output logic             coefWe,
   output logic             coefCommit,
   output logic [15:0]      sampleIn,
   output logic             sampleValid
);
   // ****************
   // Drivers
   // ****************
   initial begin
      factorIn = 9'h000;
      factorLoad = 1'b0;
      coefIn = 16'h0000;
      coefWe = 1'b0;
      coefCommit = 1'b0;
      sampleIn = 16'h0000;
      sampleValid = 1'b0;
   end
   task automatic set_factor(input logic [8:0] v);
      factorIn <= v;
      factorLoad <= 1'b1;
      @(posedge clk_sys);
      factorLoad <= 1'b0;
      factorIn <= ~v;
   endtask
   task automatic load_set(input int n, input logic [15:0] base);
      for (int k = 0; k < n; k++) begin
         coefIn <= base + k[15:0];
         coefWe <= 1'b1;
         @(posedge clk_sys);
      end
      coefWe <= 1'b0;
      coefIn <= ~coefIn;
      coefCommit <= 1'b1;
      @(posedge clk_sys);
      coefCommit <= 1'b0;
   endtask
   // Gives up after 200 cycles so a stuck ready cannot hang
   task automatic send_samples(input int n, input logic [15:0] base);
      int k;
      int g;
      k = 0;
      g = 0;
      while (k < n && g < 200) begin
         if (inputReady === 1'b1) begin
            sampleIn <= base + k[15:0];
            sampleValid <= 1'b1;
            k++;
         end else begin
            sampleValid <= 1'b0;
            sampleIn <= ~sampleIn;
         end
         g++;
         @(posedge clk_sys);
      end
      sampleValid <= 1'b0;
      sampleIn <= ~sampleIn;
   endtask
endmodule // upstream_src

// >>> test/fir_coef_reload_factor_ctrl_test.sv
`timescale 1ns/1ps
module fir_coef_reload_factor_ctrl_test;
   // ****************
   // Signals
   // ****************
   localparam logic [1:0] OK = fir_ctrl_pkg::RESP_OKAY;
   localparam logic [1:0] ER = fir_ctrl_pkg::RESP_SLVERR;
   logic        clk_sys = 1'b0, rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, sampleOutReady = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, inputReady, activeBank;
   logic        factorLoad, coefWe, coefCommit, sampleValid;
   logic        sampleOutValid;
   logic [8:0]  factorIn, activeFactor;
   logic [15:0] coefIn, sampleIn, sampleOut;
   logic [31:0] ctl [2] = '{32'h0000_0003, 32'h0000_0005};
   logic [31:0] cnt [2] = '{32'h0000_0020, 32'h0000_0021};
   logic [31:0] sel [2] = '{32'h0000_001F, 32'h0000_0020};
   logic [31:0] dat [2] = '{32'h0000_021F, 32'h0000_023F};
   logic [31:0] prv [2] = '{32'h0000_0105, 32'h0000_021F};
   logic [31:0] stl [2] = '{32'h0000_000F, 32'h0000_0007};
   int          fails = 0, check_count = 0, rxCount = 0;

   always #5 clk_sys = ~clk_sys;

   fir_coef_reload_factor_ctrl u_fir_coef_reload_factor_ctrl (
      .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .factorIn, .factorLoad, .coefIn,
      .coefWe, .coefCommit, .sampleIn, .sampleValid, .inputReady,
      .sampleOut, .sampleOutValid, .sampleOutReady, .activeFactor,
      .activeBank);
   upstream_src u_upstream_src (.clk_sys, .inputReady, .factorIn,
      .factorLoad, .coefIn, .coefWe, .coefCommit, .sampleIn, .sampleValid);

   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((s_axi_awready && s_axi_wready) !== 1'b1 && n < 50);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      check({30'h0, s_axi_bresp}, {30'h0, r});
      if (n >= 50) begin
         fails++;
         close_out();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 50);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      check(s_axi_rdata, e);
      check({30'h0, s_axi_rresp}, {30'h0, r});
      if (n >= 50) begin
         fails++;
         close_out();
      end
   endtask

   // ****************
   // Output monitor
   // ****************
   always @(posedge clk_sys) begin
      if (sampleOutValid === 1'b1 && sampleOutReady === 1'b1) begin
         check({16'h0, sampleOut}, {16'h0, 16'h0A00 + rxCount[15:0]});
         rxCount++;
      end
   end

   // ****************
   // Sequence
   // ****************
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check({31'h0, inputReady}, 32'h0000_0000);
      check({23'h0, activeFactor}, 32'h0000_0002);
      rd(fir_ctrl_pkg::OFF_STATUS, 32'h0000_0000, OK);
      rd(8'h20, 32'h0000_0000, ER);
      wr(8'h24, 32'h0000_0001, ER);
      u_upstream_src.load_set(64, 16'h0100);
      repeat (2) @(posedge clk_sys);
      check({31'h0, activeBank}, 32'h0000_0001);
      check({31'h0, inputReady}, 32'h0000_0001);
      rd(fir_ctrl_pkg::OFF_COEF_COUNT, 32'h0000_0040, OK);
      wr(fir_ctrl_pkg::OFF_COEF_SEL, 32'h0000_0005, OK);
      rd(fir_ctrl_pkg::OFF_COEF_DATA, 32'h0000_0105, OK);
      u_upstream_src.set_factor(9'h005);
      repeat (2) @(posedge clk_sys);
      check({23'h0, activeFactor}, 32'h0000_0005);
      check({31'h0, inputReady}, 32'h0000_0000);
      rd(fir_ctrl_pkg::OFF_STATUS, 32'h0000_001A, OK);
      repeat (4) @(posedge clk_sys);
      check({31'h0, inputReady}, 32'h0000_0001);
      rd(fir_ctrl_pkg::OFF_FACTOR, 32'h0000_0005, OK);
      u_upstream_src.set_factor(9'h005);
      repeat (2) @(posedge clk_sys);
      check({31'h0, inputReady}, 32'h0000_0001);
      // Symmetric then half-band trimming
      for (int m = 0; m < 2; m++) begin
         wr(fir_ctrl_pkg::OFF_CTRL, ctl[m], OK);
         // Old set must stay readable while the new one streams in
         fork
            u_upstream_src.load_set(64, 16'h0200);
            begin
               repeat (10) @(posedge clk_sys);
               rd(fir_ctrl_pkg::OFF_COEF_DATA, prv[m], OK);
               rd(fir_ctrl_pkg::OFF_STATUS, stl[m], OK);
            end
         join
         rd(fir_ctrl_pkg::OFF_COEF_COUNT, cnt[m], OK);
         wr(fir_ctrl_pkg::OFF_COEF_SEL, sel[m], OK);
         rd(fir_ctrl_pkg::OFF_COEF_DATA, dat[m], OK);
      end
      // Receiver stalls until the two-entry buffer refuses
      fork
         u_upstream_src.send_samples(4, 16'h0A00);
         begin
            repeat (6) @(posedge clk_sys);
            check({31'h0, inputReady}, 32'h0000_0000);
            sampleOutReady <= 1'b1;
         end
      join
      repeat (6) @(posedge clk_sys);
      check(rxCount, 32'h0000_0004);
      close_out();
   end
endmodule // fir_coef_reload_factor_ctrl_test

bind fir_coef_reload_factor_ctrl fir_coef_reload_factor_ctrl_sva u_sva (
   .clk_sys, .rst, .factorIn, .factorLoad, .activeFactor, .inputReady,
   .coefCommit, .activeBank, .sampleValid, .sampleOut, .sampleOutValid,
   .sampleOutReady);
